/* File: core/acq_status_consts.vh */
// Constants for the acquisition status monitor: register byte addresses,
// field positions, widths and reset values.
// Assumes inclusion by bare name from files under core/ and bench/.
`ifndef ACQ_STATUS_CONSTS_VH
`define ACQ_STATUS_CONSTS_VH

// ***********************************
// Register byte addresses
// ***********************************
`define ADDR_CTRL 8'h00
`define ADDR_ACQ_STAT 8'h0c
`define ADDR_CAM_STAT 8'h10
`define ADDR_IO_LEVELS 8'h14
`define ADDR_TRIG_CTAB 8'h18
`define ADDR_DMA_BASE 8'h40
`define ADDR_LINES_LEFT 8'h4c
`define ADDR_VIDEO 8'h50
`define ADDR_DMA_PTR 8'h58

// ***********************************
// Field positions and widths
// ***********************************
`define CTRL_TSEL_LO 0
`define CTRL_TSEL_HI 1
`define CTRL_LSCAN 2
`define CTRL_LPF_LO 16
`define CTRL_LPF_HI 31
`define LPF_W 16
`define VADDR_W 16
`define FTALLY_W 3
`define TALLY_W 2
`define IO_W 3
`define VIDEO_W 8
`define TRIG_CTAB_STATE 20

// ***********************************
// Reset values and selector codes
// ***********************************
`define CTRL_RESET 32'h0000_0000
`define DMA_BASE_RESET 32'h0000_0000
`define TSEL_DIFF 2'h0
`define TSEL_TTL 2'h1
`define TSEL_OPTO 2'h2
`define ZERO32 32'h0000_0000

`endif

/* File: core/edge_tally.v */
// One camera signal: two-flop synchroniser, edge pulses, 2-bit tally.
// Assumes the pin is asynchronous to clk_i and much slower than it.
`default_nettype none

module edge_tally (
	input wire clk_i,
	input wire rst_i,
	input wire sig_i,
	output reg level_o,
	output reg rise_o,
	output reg fall_o,
	output reg [1:0] tally_o
);

	reg meta;
	reg prev;

	// ***********************************
	// Synchroniser and edge finder
	// ***********************************
	// Only level_o reads meta, so the metastable stage feeds no logic
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta <= 1'b0;
			level_o <= 1'b0;
			prev <= 1'b0;
			rise_o <= 1'b0;
			fall_o <= 1'b0;
			tally_o <= 2'h0;
		end else begin
			meta <= sig_i;
			level_o <= meta;
			prev <= level_o;
			rise_o <= level_o & ~prev;
			fall_o <= ~level_o & prev;
			// Tally wraps naturally; a frozen value means no edges arrive
			if (level_o & ~prev) begin
				tally_o <= tally_o + 2'h1;
			end
		end
	end

endmodule

`default_nettype wire

/* File: core/acquisition_status_monitor.v */
// Acquisition status monitor: read-mostly status bank on classic Wishbone.
// Assumes camera, trigger, encoder and video pins are asynchronous to clk_i
// and that the camera pixel clock is far slower than clk_i (160 ns or more).
//
// Behaviour
// RULE1 - Vertical active flag high during active window
// RULE2 - Active window bounded by lines per frame
// RULE3 - Three-bit frame tally counts flag rises
// RULE4 - Two-bit pixel clock tally shows clock
// RULE5 - Two-bit line valid tally shows signal
// RULE6 - Two-bit frame valid tally shows signal
// RULE7 - Trigger and encoder levels always readable
// RULE8 - Selected trigger state follows source select
// RULE9 - Vertical table address counter readable
// RULE10 - Only two horizontal address bits readable
// RULE11 - Lines remaining until frame end readable
// RULE12 - Eight-bit video sample snapshot readable
// RULE13 - DMA target pointer readable, advances
// RULE14 - Every register is 32 bits wide
// RULE15 - Fields are contiguous, one to 32 bits
// RULE16 - Read-write fields return last written value
// RULE17 - Writes to read-only fields ignored
// RULE18 - Software ignores write-only field reads
// RULE19 - Camera tallies synchronised into bus clock
// RULE20 - Reset clears tallies; status read-only
`include "acq_status_consts.vh"
`default_nettype none

module acquisition_status_monitor (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire camera_pixel_clock_i,
	input wire camera_line_valid_i,
	input wire camera_frame_valid_i,
	input wire [2:0] trigger_input_levels_i,
	input wire [2:0] encoder_input_levels_i,
	input wire [7:0] camera_video_i,
	output reg vertical_active_flag_o
);

	// ***********************************
	// Camera signal tallies
	// ***********************************
	wire [2:0] cam_raw;
	wire [2:0] cam_level;
	wire [2:0] cam_rise;
	wire [2:0] cam_fall;
	wire [5:0] cam_tally;
	genvar gi;

	// Index 0 pixel clock, 1 line valid, 2 frame valid
	assign cam_raw = {camera_frame_valid_i, camera_line_valid_i, camera_pixel_clock_i};

	// RULE4 RULE5 RULE6 RULE19 - synchronised edge tallies
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_cam
			edge_tally u_tally (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.sig_i(cam_raw[gi]),
				.level_o(cam_level[gi]),
				.rise_o(cam_rise[gi]),
				.fall_o(cam_fall[gi]),
				.tally_o(cam_tally[2*gi+1:2*gi])
			);
		end
	endgenerate

	// ***********************************
	// Static input synchronisers
	// ***********************************
	reg [2:0] trig_meta;
	reg [2:0] trig_level;
	reg [2:0] enc_meta;
	reg [2:0] enc_level;
	reg [7:0] video_meta;
	reg [7:0] video_level;

	// RULE7 - two flops before any reader
	always @(posedge clk_i) begin
		if (rst_i) begin
			trig_meta <= 3'h0;
			trig_level <= 3'h0;
			enc_meta <= 3'h0;
			enc_level <= 3'h0;
			video_meta <= 8'h00;
			video_level <= 8'h00;
		end else begin
			trig_meta <= trigger_input_levels_i;
			trig_level <= trig_meta;
			enc_meta <= encoder_input_levels_i;
			enc_level <= enc_meta;
			video_meta <= camera_video_i;
			video_level <= video_meta;
		end
	end

	// ***********************************
	// Software control registers
	// ***********************************
	reg [1:0] trigger_source_select;
	reg line_scan_mode;
	reg [15:0] lines_per_frame_setting;
	reg [31:0] dma_base;
	wire bus_req;
	wire bus_wr;

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes land on the edge at which the master samples ack, never earlier
	assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	// RULE16 - byte-lane writes to read-write fields
	always @(posedge clk_i) begin
		if (rst_i) begin
			trigger_source_select <= `TSEL_DIFF;
			line_scan_mode <= 1'b0;
			lines_per_frame_setting <= 16'h0000;
			dma_base <= `DMA_BASE_RESET;
		end else if (bus_wr) begin
			if (wb_adr_i == `ADDR_CTRL) begin
				if (wb_sel_i[0]) begin
					trigger_source_select <= wb_dat_i[`CTRL_TSEL_HI:`CTRL_TSEL_LO];
					line_scan_mode <= wb_dat_i[`CTRL_LSCAN];
				end
				if (wb_sel_i[2]) begin
					lines_per_frame_setting[7:0] <= wb_dat_i[23:16];
				end
				if (wb_sel_i[3]) begin
					lines_per_frame_setting[15:8] <= wb_dat_i[31:24];
				end
			end
			if (wb_adr_i == `ADDR_DMA_BASE) begin
				if (wb_sel_i[0]) begin
					dma_base[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					dma_base[15:8] <= wb_dat_i[15:8];
				end
				if (wb_sel_i[2]) begin
					dma_base[23:16] <= wb_dat_i[23:16];
				end
				if (wb_sel_i[3]) begin
					dma_base[31:24] <= wb_dat_i[31:24];
				end
			end
		end
	end

	// ***********************************
	// Selected trigger
	// ***********************************
	reg selected_trigger_state;

	// RULE8 - follow the routed input; code 3 routes nothing
	always @(posedge clk_i) begin
		if (rst_i) begin
			selected_trigger_state <= 1'b0;
		end else begin
			case (trigger_source_select)
				`TSEL_DIFF: selected_trigger_state <= trig_level[0];
				`TSEL_TTL: selected_trigger_state <= trig_level[1];
				`TSEL_OPTO: selected_trigger_state <= trig_level[2];
				default: selected_trigger_state <= 1'b0;
			endcase
		end
	end

	// ***********************************
	// Vertical window and control tables
	// ***********************************
	reg [15:0] vertical_table_address;
	reg [15:0] lines_remaining;
	reg [15:0] horizontal_table_address;
	reg [31:0] dma_target_pointer;
	reg [7:0] video_sample_snapshot;
	reg [2:0] frame_tally;
	reg active_prev;
	wire frame_start;
	wire pixel_step;

	// Line scan has no frame valid, so a new window opens at once
	assign frame_start = ~vertical_active_flag_o & (lines_per_frame_setting != 16'h0000) &
		(line_scan_mode | cam_rise[2]);
	assign pixel_step = vertical_active_flag_o & cam_level[1] & cam_rise[0];

	// RULE1 RULE2 - window opens on frame start, closes after lpf lines
	always @(posedge clk_i) begin
		if (rst_i) begin
			vertical_active_flag_o <= 1'b0;
			vertical_table_address <= 16'h0000;
			lines_remaining <= 16'h0000;
		end else if (frame_start) begin
			vertical_active_flag_o <= 1'b1;
			vertical_table_address <= 16'h0000;
			lines_remaining <= lines_per_frame_setting;
		end else if (vertical_active_flag_o & cam_fall[1]) begin
			// RULE9 RULE11 - count lines down to window end
			vertical_table_address <= vertical_table_address + 16'h0001;
			lines_remaining <= lines_remaining - 16'h0001;
			if (lines_remaining == 16'h0001) begin
				vertical_active_flag_o <= 1'b0;
			end
		end
	end

	// Horizontal address restarts each line; DMA pointer per pixel
	always @(posedge clk_i) begin
		if (rst_i) begin
			horizontal_table_address <= 16'h0000;
			dma_target_pointer <= `ZERO32;
		end else begin
			if (cam_rise[1]) begin
				horizontal_table_address <= 16'h0000;
			end else if (pixel_step) begin
				horizontal_table_address <= horizontal_table_address + 16'h0001;
			end
			// RULE13 - pointer reloads per frame, moves per pixel
			if (frame_start) begin
				dma_target_pointer <= dma_base;
			end else if (pixel_step) begin
				dma_target_pointer <= dma_target_pointer + 32'h0000_0001;
			end
		end
	end

	// Video data shares the pixel clock's sync delay, so it is stable here
	always @(posedge clk_i) begin
		if (rst_i) begin
			video_sample_snapshot <= 8'h00;
		end else if (cam_rise[0]) begin
			// RULE12 - capture the whole video byte
			video_sample_snapshot <= video_level;
		end
	end

	// RULE3 RULE20 - frame tally on flag rise, cleared by reset
	always @(posedge clk_i) begin
		if (rst_i) begin
			active_prev <= 1'b0;
			frame_tally <= 3'h0;
		end else begin
			active_prev <= vertical_active_flag_o;
			if (vertical_active_flag_o & ~active_prev) begin
				frame_tally <= frame_tally + 3'h1;
			end
		end
	end

	// ***********************************
	// Read multiplexer and acknowledge
	// ***********************************
	reg [31:0] next_rdata;

	// RULE14 RULE15 - 32-bit words, contiguous fields, spare bits zero
	always @* begin
		next_rdata = `ZERO32;
		case (wb_adr_i)
			`ADDR_CTRL: begin
				next_rdata[`CTRL_TSEL_HI:`CTRL_TSEL_LO] = trigger_source_select;
				next_rdata[`CTRL_LSCAN] = line_scan_mode;
				next_rdata[`CTRL_LPF_HI:`CTRL_LPF_LO] = lines_per_frame_setting;
			end
			`ADDR_ACQ_STAT: next_rdata[3:0] = {frame_tally, vertical_active_flag_o};
			`ADDR_CAM_STAT: next_rdata[5:0] = cam_tally;
			`ADDR_IO_LEVELS: next_rdata[6:0] = {enc_level, 1'b0, trig_level};
			`ADDR_TRIG_CTAB: begin
				next_rdata[15:0] = vertical_table_address;
				// RULE10 - only the low two address bits
				next_rdata[17:16] = horizontal_table_address[1:0];
				next_rdata[`TRIG_CTAB_STATE] = selected_trigger_state;
			end
			`ADDR_DMA_BASE: next_rdata = dma_base;
			`ADDR_LINES_LEFT: next_rdata[15:0] = lines_remaining;
			`ADDR_VIDEO: next_rdata[7:0] = video_sample_snapshot;
			`ADDR_DMA_PTR: next_rdata = dma_target_pointer;
			default: next_rdata = `ZERO32;
		endcase
	end

	// RULE17 - status addresses have no write path, so writes just ack
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `ZERO32;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

endmodule

`default_nettype wire

/* File: bench/camera_model.sv */
// Camera stand-in: frame valid, line valid, pixel clock and video byte.
// Assumes clk_i is the 100 MHz bench clock and start_i pulses once a frame.
`default_nettype none
module camera_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [7:0] video_value_i,
	output logic pclk_o,
	output logic lv_o,
	output logic fv_o,
	output logic [7:0] video_o,
	output logic busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// Frame generator
	// ****************
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Five lines of three pixels; 160 ns pixel clock stands still between lines
	initial begin
		{pclk_o, lv_o, fv_o, busy_o} = 4'h0;
		video_o = 8'ha5;
		forever begin
			@(posedge clk_i);
			if (start_i) begin
				busy_o <= 1'b1;
				fv_o <= 1'b1;
				hold(16);
				repeat (5) begin
					lv_o <= 1'b1;
					video_o <= video_value_i;
					repeat (3) begin
						hold(8);
						pclk_o <= 1'b1;
						hold(8);
						pclk_o <= 1'b0;
					end
					hold(8);
					lv_o <= 1'b0;
					video_o <= ~video_value_i; // Released bus shows junk, not old data
					hold(16);
				end
				fv_o <= 1'b0;
				hold(16);
				busy_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: bench/acq_status_sva.sv */
// Bus and window checks on the status monitor's ports.
// Assumes a single clock domain; attached to the monitor by bind.
`include "acq_status_consts.vh"
`default_nettype none
module acq_status_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic camera_pixel_clock_i,
	input wire logic camera_line_valid_i,
	input wire logic camera_frame_valid_i,
	input wire logic [2:0] trigger_input_levels_i,
	input wire logic [2:0] encoder_input_levels_i,
	input wire logic [7:0] camera_video_i,
	input wire logic vertical_active_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic rd_pend;
	logic [7:0] rd_adr;
	logic lscan;
	// Shadow of the line scan bit: such windows open without frame valid
	always_ff @(posedge clk_i) begin
		if (rst_i)
			lscan <= 1'b0;
		else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `ADDR_CTRL
			&& wb_sel_i[0])
			lscan <= wb_dat_i[`CTRL_LSCAN];
	end
	// Remember the last accepted read so its answer can be judged
	always_ff @(posedge clk_i) begin
		rd_pend <= wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
		rd_adr <= wb_adr_i;
	end
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
	property p_unmapped;
		wb_ack_o && rd_pend && rd_adr == 8'h04 |-> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("hole not zero");
	property p_ctrl_rsvd;
		wb_ack_o && rd_pend && rd_adr == `ADDR_CTRL |-> wb_dat_o[15:3] == 13'h0;
	endproperty
	a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("spare bits set");
	property p_stat_flag;
		wb_ack_o && rd_pend && rd_adr == `ADDR_ACQ_STAT
			|-> wb_dat_o[0] == $past(vertical_active_flag_o) && wb_dat_o[31:4] == 28'h0;
	endproperty
	a_stat_flag: assert property (p_stat_flag) else $error("flag read wrong");
	property p_flag_rise;
		$rose(vertical_active_flag_o) && !lscan |-> $past(camera_frame_valid_i, 2);
	endproperty
	a_flag_rise: assert property (p_flag_rise) else $error("window outside frame");
	property p_flag_fall;
		$fell(vertical_active_flag_o) |-> !$past(camera_line_valid_i, 2);
	endproperty
	a_flag_fall: assert property (p_flag_fall) else $error("window cut mid line");
	// Reset itself must clear outputs, so this one is not disabled by it
	property p_reset;
		disable iff (1'b0) rst_i |=> !wb_ack_o && wb_dat_o == 32'h0 && !vertical_active_flag_o;
	endproperty
	a_reset: assert property (p_reset) else $error("reset left state");
endmodule
bind acquisition_status_monitor acq_status_sva chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.camera_pixel_clock_i(camera_pixel_clock_i), .camera_line_valid_i(camera_line_valid_i),
	.camera_frame_valid_i(camera_frame_valid_i), .camera_video_i(camera_video_i),
	.trigger_input_levels_i(trigger_input_levels_i),
	.encoder_input_levels_i(encoder_input_levels_i),
	.vertical_active_flag_o(vertical_active_flag_o));
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench: Wishbone register traffic plus area and line scan frames.
// Assumes the monitor answers every access and a camera_model drives the link.
`include "acq_status_consts.vh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rst_i, cyc, stb, we, ack, flag, start, pclk, lv, fv, busy;
	logic [7:0] adr, video;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, dat_o;
	logic [2:0] trig, enc, tv, ev;
	int fails, check_count, n;
	acquisition_status_monitor dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .camera_pixel_clock_i(pclk),
		.camera_line_valid_i(lv), .camera_frame_valid_i(fv), .trigger_input_levels_i(trig),
		.encoder_input_levels_i(enc), .camera_video_i(video), .vertical_active_flag_o(flag));
	camera_model cam_u (.clk_i(clk_i), .start_i(start), .video_value_i(8'h5a),
		.pclk_o(pclk), .lv_o(lv), .fv_o(fv), .video_o(video), .busy_o(busy));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// ****************
	// Access tasks
	// ****************
	task automatic results();
		if (fails == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask
	// Request held until ack is sampled; read data taken at that same edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rdat = dat_o;
		{cyc, stb} <= 2'b00;
		if (n >= 50) begin
			fails++;
			results();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 4'hf, 32'h0);
		chk(rdat, exp);
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		{rst_i, cyc, stb, we, start, adr, sel, wdat, trig, enc} = {1'b1, 54'h0};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`ADDR_CTRL, 32'h0);
		rd(`ADDR_CAM_STAT, 32'h0);
		xfer(1'b1, `ADDR_ACQ_STAT, 4'hf, 32'hffff_ffff);
		rd(`ADDR_ACQ_STAT, 32'h0);
		// bench relies on no write-only read-back
		rd(8'h04, 32'h0);
		xfer(1'b1, `ADDR_CTRL, 4'hf, 32'h0003_0001);
		rd(`ADDR_CTRL, 32'h0003_0001);
		xfer(1'b1, `ADDR_CTRL, 4'h1, 32'hffff_ff02);
		rd(`ADDR_CTRL, 32'h0003_0002);
		xfer(1'b1, `ADDR_DMA_BASE, 4'hf, 32'h0000_1000);
		rd(`ADDR_DMA_BASE, 32'h0000_1000);
		// Every trigger source against two level patterns
		for (int p = 0; p < 2; p++) begin
			tv = p ? 3'b010 : 3'b101;
			ev = p ? 3'b100 : 3'b011;
			trig <= tv;
			enc <= ev;
			for (int s = 0; s < 4; s++) begin
				xfer(1'b1, `ADDR_CTRL, 4'h1, {30'h0, s[1:0]});
				rd(`ADDR_IO_LEVELS, {25'h0, ev, 1'b0, tv});
				rd(`ADDR_TRIG_CTAB, {11'h0, (s < 3) && tv[s], 20'h0});
			end
		end
		// Five-line frames against a three-line window
		for (int f = 1; f <= 2; f++) begin
			start <= 1'b1;
			@(posedge clk_i);
			start <= 1'b0;
			n = 0;
			while (flag !== 1'b1 && n < 200) begin
				@(posedge clk_i);
				n++;
			end
			chk({31'h0, flag}, 32'h1);
			n = 0;
			while (busy !== 1'b0 && n < 2000) begin
				@(posedge clk_i);
				n++;
			end
			if (n >= 2000)
				fails++;
			chk({31'h0, flag}, 32'h0);
			rd(`ADDR_ACQ_STAT, {28'h0, f[2:0], 1'b0});
			rd(`ADDR_CAM_STAT, {26'h0, f[1:0], 2'(5 * f), 2'(15 * f)});
			rd(`ADDR_LINES_LEFT, 32'h0);
			rd(`ADDR_DMA_PTR, 32'h0000_1009);
			rd(`ADDR_VIDEO, 32'h0000_005a);
			rd(`ADDR_TRIG_CTAB, 32'h0000_0003);
		end
		// Line scan: window opens at once, closes after three lines, reopens
		xfer(1'b1, `ADDR_CTRL, 4'h1, 32'h0000_0005);
		repeat (2) @(posedge clk_i);
		chk({31'h0, flag}, 32'h1);
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (busy !== 1'b0 && n < 2000);
		if (n >= 2000)
			fails++;
		chk({31'h0, flag}, 32'h1);
		rd(`ADDR_ACQ_STAT, 32'h0000_0009);
		rd(`ADDR_LINES_LEFT, 32'h0000_0001);
		rd(`ADDR_TRIG_CTAB, 32'h0013_0002);
		rd(`ADDR_DMA_PTR, 32'h0000_1006);
		rd(`ADDR_CAM_STAT, 32'h0000_003d);
		// A second reset must clear what the frames left behind
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`ADDR_ACQ_STAT, 32'h0);
		rd(`ADDR_CAM_STAT, 32'h0);
		results();
	end
endmodule
`default_nettype wire
